// file: fpc_params.svh
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH
// Behaviour
// - A manual loop_oscillator calibration starts only on a 0 to 1 change of the calibration bit, never while it stays high.
// - The loop sync bit acts as a distribution sync command to every output divider clocked from the fractional_loop.
// - While the loop sync bit is 1 those dividers are held synchronized, and they run normally again when it returns to 0.
// - The doubler enable bit routes the reference_predivider output when 0 and the doubled reference when 1.
// - The loop mode field selects single (00), cascaded (01) or fixed delay (10) feedback, and code 11 is reserved.
// - The eight-bit pump current code gives four microamps per step and resets to 0x8d.
// - The second_pole_resistor code selects 2000, 666, 400 or 285 ohms and resets to 3.
// - The zero_resistor code selects 1500 to 4125 ohms in eight steps and resets to 5.
// - The first_pole_capacitor code selects 2 to 122 picofarads and resets to 0.
// - The reference_predivider ratio is a six-bit value from 1 to 63, 0 reserved, resetting to 1.

// Register indices as printed; byte address is four times the index
`define FPC_IDX_CTRL       12'h100
`define FPC_IDX_PATH       12'h101
`define FPC_IDX_PUMP       12'h102
`define FPC_IDX_FILT       12'h103
`define FPC_IDX_PREDIV     12'h105
`define FPC_IDX_STATUS     12'h1f0
`define FPC_ADDR_CTRL      (`FPC_IDX_CTRL * 4)
`define FPC_ADDR_PATH      (`FPC_IDX_PATH * 4)
`define FPC_ADDR_PUMP      (`FPC_IDX_PUMP * 4)
`define FPC_ADDR_FILT      (`FPC_IDX_FILT * 4)
`define FPC_ADDR_PREDIV    (`FPC_IDX_PREDIV * 4)
`define FPC_ADDR_STATUS    (`FPC_IDX_STATUS * 4)

// Field positions
`define FPC_CTRL_CAL       3
`define FPC_CTRL_SYNC      2
`define FPC_CTRL_PDN       1
`define FPC_CTRL_RST       0
`define FPC_PATH_DBL       3
`define FPC_PATH_MODE_HI   2
`define FPC_PATH_MODE_LO   1
`define FPC_PATH_MPDN      0
`define FPC_FILT_RP2_HI    7
`define FPC_FILT_RP2_LO    6
`define FPC_FILT_RZ_HI     5
`define FPC_FILT_RZ_LO     3
`define FPC_FILT_CP1_HI    2
`define FPC_FILT_CP1_LO    0
`define FPC_STAT_BUSY      0
`define FPC_STAT_DONE      1

// Reset values
`define FPC_RST_CTRL       8'h00
`define FPC_RST_PATH       8'h01
`define FPC_RST_PUMP       8'h8d
`define FPC_RST_RP2        2'h3
`define FPC_RST_RZ         3'h5
`define FPC_RST_CP1        3'h0
`define FPC_RST_PREDIV     6'h01

// Timing
`define FPC_CLK_PERIOD_NS  50
`define FPC_CAL_TIME_NS    100000
`define FPC_CAL_CYCLES     ((`FPC_CAL_TIME_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)
`endif

// file: fpc_pkg.sv
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_MODE_SINGLE,
    FPC_MODE_CASCADE,
    FPC_MODE_FIXED_DELAY,
    FPC_MODE_RESERVED
  } fpc_loop_mode_t;

  typedef enum logic {
    FPC_CAL_IDLE,
    FPC_CAL_RUN
  } fpc_cal_state_t;
endpackage

// file: fpc_cal_if.sv
`timescale 1ns/1ps
// Calibration handshake between the register bank and the sequencer
interface fpc_cal_if;
  logic cal_bit;
  logic loop_hold;
  logic cal_start;
  logic cal_busy;
  logic cal_done;

  modport bank (output cal_bit, output loop_hold, input cal_start, input cal_busy, input cal_done);
  modport seq  (input cal_bit, input loop_hold, output cal_start, output cal_busy, output cal_done);
endinterface

// file: fpc_cal_seq.sv
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_cal_seq
  import fpc_pkg::*;
#(
  parameter int CAL_CYCLES = `FPC_CAL_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  fpc_cal_if.seq    cal
);
  localparam int CW = $clog2(CAL_CYCLES + 1);

  initial begin
    if (CAL_CYCLES < 1) begin
      $error("fpc_cal_seq: CAL_CYCLES must be at least 1");
    end
  end

  logic           cal_prev_q;
  logic           rise;
  fpc_cal_state_t state_q;
  logic [CW-1:0]  cnt_q;

  // Edge detect on the stored bit; holding it high gives one edge only
  assign rise = cal.cal_bit & ~cal_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_prev_q <= 1'b0;
    end else begin
      cal_prev_q <= cal.cal_bit;
    end
  end

  // Start pulse, one cycle per rising edge while the loop is neither powered down nor held in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal.cal_start <= 1'b0;
    end else begin
      cal.cal_start <= rise & ~cal.loop_hold;
    end
  end

  // Busy window; a new edge restarts it, a powered-down or reset loop aborts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q      <= FPC_CAL_IDLE;
      cnt_q        <= '0;
      cal.cal_busy <= 1'b0;
      cal.cal_done <= 1'b0;
    end else begin
      // Done is a one-cycle pulse so a software clear of the sticky flag can take hold
      cal.cal_done <= 1'b0;
      case (state_q)
        FPC_CAL_IDLE: begin
          if (rise && !cal.loop_hold) begin
            state_q      <= FPC_CAL_RUN;
            cnt_q        <= CW'(CAL_CYCLES);
            cal.cal_busy <= 1'b1;
            cal.cal_done <= 1'b0;
          end
        end
        FPC_CAL_RUN: begin
          if (cal.loop_hold) begin
            state_q      <= FPC_CAL_IDLE;
            cal.cal_busy <= 1'b0;
          end else if (rise) begin
            cnt_q <= CW'(CAL_CYCLES);
          end else if (cnt_q == CW'(1)) begin
            state_q      <= FPC_CAL_IDLE;
            cal.cal_busy <= 1'b0;
            cal.cal_done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: begin
          state_q <= FPC_CAL_IDLE;
        end
      endcase
    end
  end
endmodule

// file: fpc_cfg_top.sv
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_cfg_top
  import fpc_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int CAL_CYCLES = `FPC_CAL_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Analog loop controls
  output logic                   loop_pdn,
  output logic                   loop_rst,
  output logic                   mod_pdn,
  output logic                   div_sync_hold,
  output logic                   doubler_sel,
  output fpc_loop_mode_t         loop_mode,
  output logic [7:0]             pump_code,
  output logic [1:0]             second_pole_resistor,
  output logic [2:0]             zero_resistor,
  output logic [2:0]             first_pole_capacitor,
  output logic [5:0]             reference_predivider,
  output logic                   cal_start,
  output logic                   cal_busy
);

  initial begin
    if (ADDR_W < 12 || ADDR_W > 32) begin
      $error("fpc_cfg_top: ADDR_W must be 12 to 32");
    end
  end

  // Register storage
  logic           cal_q;
  logic           sync_q;
  logic           pdn_q;
  logic           lrst_q;
  logic           dbl_q;
  fpc_loop_mode_t mode_q;
  logic           mpdn_q;
  logic [7:0]     pump_q;
  logic [1:0]     rp2_q;
  logic [2:0]     rz_q;
  logic [2:0]     cp1_q;
  logic [5:0]     prediv_q;
  logic           done_q;

  // Whole reset bytes, so single bits are picked by position without truncation
  localparam logic [7:0] RST_CTRL_V = `FPC_RST_CTRL;
  localparam logic [7:0] RST_PATH_V = `FPC_RST_PATH;

  // Bus handshake state
  logic           pready_q;
  logic [31:0]    prdata_q;
  logic           pslverr_q;
  logic           setup;
  logic           wr_fire;
  logic [7:0]     wbyte;

  fpc_cal_if cal_bus ();

  // Address decode shared by the read mux and the write path
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [31:0] byte_addr);
    addr_is = (a == ADDR_W'(byte_addr));
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_is(a, `FPC_ADDR_CTRL) || addr_is(a, `FPC_ADDR_PATH) ||
                  addr_is(a, `FPC_ADDR_PUMP) || addr_is(a, `FPC_ADDR_FILT) ||
                  addr_is(a, `FPC_ADDR_PREDIV) || addr_is(a, `FPC_ADDR_STATUS);
  endfunction

  // Read view of each register; reserved bits read zero
  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (addr_is(a, `FPC_ADDR_CTRL)) begin
      v[`FPC_CTRL_CAL]  = cal_q;
      v[`FPC_CTRL_SYNC] = sync_q;
      v[`FPC_CTRL_PDN]  = pdn_q;
      v[`FPC_CTRL_RST]  = lrst_q;
    end else if (addr_is(a, `FPC_ADDR_PATH)) begin
      v[`FPC_PATH_DBL]                        = dbl_q;
      v[`FPC_PATH_MODE_HI:`FPC_PATH_MODE_LO] = mode_q;
      v[`FPC_PATH_MPDN]                       = mpdn_q;
    end else if (addr_is(a, `FPC_ADDR_PUMP)) begin
      v = pump_q;
    end else if (addr_is(a, `FPC_ADDR_FILT)) begin
      v = {rp2_q, rz_q, cp1_q};
    end else if (addr_is(a, `FPC_ADDR_PREDIV)) begin
      v = {2'h0, prediv_q};
    end else if (addr_is(a, `FPC_ADDR_STATUS)) begin
      v[`FPC_STAT_BUSY] = cal_bus.cal_busy;
      v[`FPC_STAT_DONE] = done_q;
    end
    read_reg = v;
  endfunction

  // No wait state: answer is prepared in setup, presented in the first access cycle
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready_q & pwrite & ~pslverr_q & pstrb[0];
  assign wbyte   = pwdata[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~addr_mapped(paddr);
    end
  end

  // Read data captured in setup so it is stable when pready rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= {24'h00_0000, read_reg(paddr)};
    end else if (!psel) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Loop control register: calibration, sync, power-down, reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_q  <= RST_CTRL_V[`FPC_CTRL_CAL];
      sync_q <= 1'b0;
      pdn_q  <= 1'b0;
      lrst_q <= 1'b0;
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_CTRL)) begin
      cal_q  <= wbyte[`FPC_CTRL_CAL];
      sync_q <= wbyte[`FPC_CTRL_SYNC];
      pdn_q  <= wbyte[`FPC_CTRL_PDN];
      lrst_q <= wbyte[`FPC_CTRL_RST];
    end
  end

  // Path select register; the reserved loop mode code is refused and the old mode kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbl_q  <= RST_PATH_V[`FPC_PATH_DBL];
      mode_q <= FPC_MODE_SINGLE;
      mpdn_q <= RST_PATH_V[`FPC_PATH_MPDN];
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_PATH)) begin
      dbl_q  <= wbyte[`FPC_PATH_DBL];
      mpdn_q <= wbyte[`FPC_PATH_MPDN];
      if (wbyte[`FPC_PATH_MODE_HI:`FPC_PATH_MODE_LO] != FPC_MODE_RESERVED) begin
        mode_q <= fpc_loop_mode_t'(wbyte[`FPC_PATH_MODE_HI:`FPC_PATH_MODE_LO]);
      end
    end
  end

  // Charge pump current, 4 uA per step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_q <= `FPC_RST_PUMP;
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_PUMP)) begin
      pump_q <= wbyte;
    end
  end

  // Loop filter codes; the capacitor code 111 has no defined value and is refused
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp2_q <= `FPC_RST_RP2;
      rz_q  <= `FPC_RST_RZ;
      cp1_q <= `FPC_RST_CP1;
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_FILT)) begin
      rp2_q <= wbyte[`FPC_FILT_RP2_HI:`FPC_FILT_RP2_LO];
      rz_q  <= wbyte[`FPC_FILT_RZ_HI:`FPC_FILT_RZ_LO];
      if (wbyte[`FPC_FILT_CP1_HI:`FPC_FILT_CP1_LO] != 3'h7) begin
        cp1_q <= wbyte[`FPC_FILT_CP1_HI:`FPC_FILT_CP1_LO];
      end
    end
  end

  // Predivider ratio; zero is reserved so a write of zero is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prediv_q <= `FPC_RST_PREDIV;
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_PREDIV) && wbyte[5:0] != 6'h00) begin
      prediv_q <= wbyte[5:0];
    end
  end

  // Sticky done flag; completion wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (cal_bus.cal_done) begin
      done_q <= 1'b1;
    end else if (wr_fire && addr_is(paddr, `FPC_ADDR_STATUS) && wbyte[`FPC_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Analog outputs registered once more so glitches from decode never reach the loop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_pdn      <= 1'b0;
      loop_rst      <= 1'b0;
      mod_pdn       <= 1'b1;
      div_sync_hold <= 1'b0;
      doubler_sel   <= 1'b0;
      loop_mode     <= FPC_MODE_SINGLE;
    end else begin
      loop_pdn      <= pdn_q;
      loop_rst      <= lrst_q;
      mod_pdn       <= mpdn_q;
      div_sync_hold <= sync_q;
      doubler_sel   <= dbl_q;
      loop_mode     <= mode_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_code            <= `FPC_RST_PUMP;
      second_pole_resistor <= `FPC_RST_RP2;
      zero_resistor        <= `FPC_RST_RZ;
      first_pole_capacitor <= `FPC_RST_CP1;
      reference_predivider <= `FPC_RST_PREDIV;
    end else begin
      pump_code            <= pump_q;
      second_pole_resistor <= rp2_q;
      zero_resistor        <= rz_q;
      first_pole_capacitor <= cp1_q;
      reference_predivider <= prediv_q;
    end
  end

  // Calibration is suppressed while the loop is powered down or held in reset
  assign cal_bus.cal_bit   = cal_q;
  assign cal_bus.loop_hold = pdn_q | lrst_q;

  fpc_cal_seq #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal (
    .clk (clk),
    .rst (rst),
    .cal (cal_bus.seq)
  );

  // Bus and calibration outputs come straight from flip-flops
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q; // Only ever set together with pready_q
  assign cal_start = cal_bus.cal_start;
  assign cal_busy  = cal_bus.cal_busy;
endmodule

// file: fpc_cfg_props.sv
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_cfg_props
  import fpc_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int CAL_CYCLES = 4
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              div_sync_hold,
  input wire fpc_loop_mode_t    loop_mode,
  input wire logic [7:0]        pump_code,
  input wire logic [2:0]        first_pole_capacitor,
  input wire logic [5:0]        reference_predivider,
  input wire logic              cal_start,
  input wire logic              cal_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        mapped;
  logic [15:0] busy_cnt_q;
  // Decode of every register the bank answers for
  assign mapped = (paddr == `FPC_ADDR_CTRL) || (paddr == `FPC_ADDR_PATH) || (paddr == `FPC_ADDR_PUMP) ||
                  (paddr == `FPC_ADDR_FILT) || (paddr == `FPC_ADDR_PREDIV) || (paddr == `FPC_ADDR_STATUS);
  // Busy length counter; restarts on each start so a recalibration is measured afresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 16'h0;
    end else if (cal_start) begin
      busy_cnt_q <= 16'h1;
    end else if (cal_busy) begin
      busy_cnt_q <= busy_cnt_q + 16'h1;
    end
  end
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_wr_ctrl;
    s_access ##0 (pwrite && pstrb[0] && paddr == `FPC_ADDR_CTRL);
  endsequence
  sequence s_wr_pump;
    s_access ##0 (pwrite && pstrb[0] && paddr == `FPC_ADDR_PUMP);
  endsequence
  chk_ready_one_cycle: assert property (s_access |=> !pready) else $error("pready held too long");
  chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
  chk_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  chk_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr) else $error("no error on unmapped");
  chk_err_mapped: assert property (s_access ##0 mapped |-> !pslverr) else $error("error on mapped register");
  chk_sync_follow: assert property (s_wr_ctrl |-> ##2 div_sync_hold == $past(pwdata[2], 2))
    else $error("sync hold not following register");
  chk_pump_follow: assert property (s_wr_pump |-> ##2 pump_code == $past(pwdata[7:0], 2))
    else $error("pump code not following register");
  chk_start_cause: assert property (cal_start |-> $past(pwrite && paddr == `FPC_ADDR_CTRL && pwdata[3], 2))
    else $error("calibration start without write");
  chk_start_pulse: assert property (cal_start |-> cal_busy ##1 !cal_start) else $error("start not a pulse");
  chk_busy_length: assert property ($fell(cal_busy) |-> busy_cnt_q == CAL_CYCLES) else $error("busy length wrong");
  chk_mode_legal: assert property (loop_mode != FPC_MODE_RESERVED) else $error("reserved loop mode");
  chk_cap_legal: assert property (first_pole_capacitor != 3'h7) else $error("capacitor code 7");
  chk_prediv_legal: assert property (reference_predivider != 6'h00) else $error("predivider zero");
endmodule

bind fpc_cfg_top fpc_cfg_props #(.ADDR_W(ADDR_W), .CAL_CYCLES(CAL_CYCLES)) props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .div_sync_hold(div_sync_hold), .loop_mode(loop_mode), .pump_code(pump_code),
  .first_pole_capacitor(first_pole_capacitor), .reference_predivider(reference_predivider),
  .cal_start(cal_start), .cal_busy(cal_busy));

// file: tb_fractional_pll_config_regs.sv
`timescale 1ns/1ps
`include "fpc_params.svh"
module tb_fractional_pll_config_regs;
  import fpc_pkg::*;
  localparam int CAL_N = 4;
  logic           clk, rst, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd, pv;
  logic [3:0]     pstrb;
  logic           loop_pdn, loop_rst, mod_pdn, div_sync_hold, doubler_sel, cal_start, cal_busy;
  fpc_loop_mode_t loop_mode;
  logic [7:0]     pump_code;
  logic [1:0]     rp2;
  logic [2:0]     rz, cp;
  logic [5:0]     prediv;
  int             err_total, checked, starts, cycles;

  fpc_cfg_top #(.ADDR_W(12), .CAL_CYCLES(CAL_N)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .loop_pdn(loop_pdn), .loop_rst(loop_rst), .mod_pdn(mod_pdn), .div_sync_hold(div_sync_hold),
    .doubler_sel(doubler_sel), .loop_mode(loop_mode), .pump_code(pump_code),
    .second_pole_resistor(rp2), .zero_resistor(rz), .first_pole_capacitor(cp),
    .reference_predivider(prediv), .cal_start(cal_start), .cal_busy(cal_busy));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Start pulse counter and cycle ceiling; the tests need about 150 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cal_start === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high, bounded wait
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    serr = pslverr;
    if (n >= 16) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h0, 32'h0};
    pstrb = 4'hf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(`FPC_ADDR_CTRL, 32'h00, "ctrl reset");
    rdchk(`FPC_ADDR_PATH, 32'h01, "path reset");
    rdchk(`FPC_ADDR_PUMP, 32'h8d, "pump reset");
    rdchk(`FPC_ADDR_FILT, 32'he8, "filter reset");
    rdchk(`FPC_ADDR_PREDIV, 32'h01, "predivider reset");
    chk("reset pins", {8'h0, mod_pdn, pump_code, rp2, rz, cp, prediv}, {8'h0, 1'b1, 8'h8d, 8'he8, 6'h01});
    $display("test reset done");
    // Sync, power-down and reset bits set together then cleared
    wr(`FPC_ADDR_CTRL, 32'h07);
    rdchk(`FPC_ADDR_CTRL, 32'h07, "ctrl");
    chk("ctrl pins", 32'h7, {29'h0, div_sync_hold, loop_pdn, loop_rst});
    wr(`FPC_ADDR_CTRL, 32'h00);
    rdchk(`FPC_ADDR_CTRL, 32'h00, "ctrl");
    chk("ctrl pins", 32'h0, {29'h0, div_sync_hold, loop_pdn, loop_rst});
    $display("test control done");
    // Every legal loop mode, then the reserved code must leave mode 2
    for (int m = 0; m < 3; m++) begin
      pv = {28'h0, m[0], m[1:0], ~m[0]};
      wr(`FPC_ADDR_PATH, pv);
      rdchk(`FPC_ADDR_PATH, pv, "path");
      chk("path pins", pv, {28'h0, doubler_sel, loop_mode, mod_pdn});
    end
    wr(`FPC_ADDR_PATH, 32'h0f);
    rdchk(`FPC_ADDR_PATH, 32'h0d, "path");
    chk("path pins", 32'hd, {28'h0, doubler_sel, loop_mode, mod_pdn});
    $display("test path done");
    // Pump full scale, a strobe-less write, then zero
    wr(`FPC_ADDR_PUMP, 32'hff);
    pstrb <= 4'h0;
    wr(`FPC_ADDR_PUMP, 32'h00);
    pstrb <= 4'hf;
    rdchk(`FPC_ADDR_PUMP, 32'hff, "pump");
    chk("pump pins", 32'hff, {24'h0, pump_code});
    wr(`FPC_ADDR_PUMP, 32'h00);
    rdchk(`FPC_ADDR_PUMP, 32'h00, "pump");
    chk("pump pins", 32'h0, {24'h0, pump_code});
    $display("test pump done");
    // Filter codes, then capacitor code 7 is refused
    wr(`FPC_ADDR_FILT, 32'h3e);
    rdchk(`FPC_ADDR_FILT, 32'h3e, "filter");
    chk("filter pins", 32'h3e, {24'h0, rp2, rz, cp});
    wr(`FPC_ADDR_FILT, 32'hc7);
    rdchk(`FPC_ADDR_FILT, 32'hc6, "filter");
    chk("filter pins", 32'hc6, {24'h0, rp2, rz, cp});
    $display("test filter done");
    // Predivider top value, then zero is ignored
    wr(`FPC_ADDR_PREDIV, 32'h3f);
    wr(`FPC_ADDR_PREDIV, 32'h00);
    rdchk(`FPC_ADDR_PREDIV, 32'h3f, "predivider");
    chk("predivider pin", 32'h3f, {26'h0, prediv});
    $display("test predivider done");
    // Unmapped places answer with an error
    xfer(1'b0, 12'h410, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, serr});
    wr(12'h7fc, 32'hff);
    chk("unmapped write error", 32'h1, {31'h0, serr});
    $display("test unmapped done");
    // Calibration starts on a rise only
    wr(`FPC_ADDR_CTRL, 32'h08);
    repeat (CAL_N + 6) @(posedge clk);
    chk("start count", 32'd1, 32'(starts));
    rdchk(`FPC_ADDR_STATUS, 32'h2, "status done");
    wr(`FPC_ADDR_CTRL, 32'h08);
    repeat (CAL_N + 6) @(posedge clk);
    chk("start count held", 32'd1, 32'(starts));
    wr(`FPC_ADDR_CTRL, 32'h00);
    wr(`FPC_ADDR_CTRL, 32'h08);
    repeat (CAL_N + 6) @(posedge clk);
    chk("start count again", 32'd2, 32'(starts));
    wr(`FPC_ADDR_STATUS, 32'h2);
    rdchk(`FPC_ADDR_STATUS, 32'h0, "status cleared");
    $display("test calibration done");
    final_report();
  end
endmodule
